// ---- hw/serial_port_pkg.sv ----
// Overview of operation
// [RULE1] two mode bits select four frame modes
// [RULE2] power bit makes top bit framing flag
// [RULE3] framing flag sets on bad stop, sticky
// [RULE4] modes 2/3 multiprocessor: ninth zero blocks flag
// [RULE5] mode 1 multiprocessor: bad stop blocks flag
// [RULE6] mode 0 multiprocessor bit picks clock 12/4
// [RULE7] receive only while receive enable set
// [RULE8] modes 2/3 send software ninth bit
// [RULE9] ninth status: ninth bit or mode-1 stop
// [RULE10] transmit flag at eighth end or stop start
// [RULE11] receive flag at eighth end or mid-stop
// [RULE12] data address: read receive, write transmit
// [RULE13] software programs slave address register
// [RULE14] masked bits compare received address bits
// [RULE15] unmasked address bits are ignored
// [RULE16] all-zero mask accepts any address
// [RULE17] second port uses own address, mask
// [RULE18] port interrupt needs its own enable
// [RULE19] global enable gates serial interrupts
// [RULE20] priority bit selects higher level
// [RULE21] transmit and receive on two pins
// [RULE22] data write starts frame, flag at end
package serial_port_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL  = 8'h98;
	localparam logic [7:0] IDX_DATA     = 8'h99;
	localparam logic [7:0] IDX_SADDR0   = 8'hA9;
	localparam logic [7:0] IDX_SLAVE_ADDRESS_PORT1   = 8'hAA;
	localparam logic [7:0] IDX_MASK0    = 8'hB9;
	localparam logic [7:0] IDX_MASK1    = 8'hBA;
	localparam logic [7:0] IDX_POWER    = 8'hC8;
	localparam logic [7:0] IDX_IRQ_CTRL = 8'hC9;
	localparam logic [7:0] IDX_BAUD_LO  = 8'hCA;
	localparam logic [7:0] IDX_BAUD_HI  = 8'hCB;

	// serial_control fields
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_MP      = 5;
	localparam int BIT_REN     = 4;
	localparam int BIT_TB8     = 3;
	localparam int BIT_RB8     = 2;
	localparam int BIT_TI      = 1;
	localparam int BIT_RI      = 0;
	// power_control_register fields
	localparam int BIT_DOUBLE  = 7;
	localparam int BIT_FE_SEL  = 6;
	// interrupt control fields
	localparam int BIT_GIE     = 7;
	localparam int BIT_ES      = 4;
	localparam int BIT_PS      = 0;

	localparam logic [1:0] MODE_SYNC   = 2'h0;
	localparam logic [1:0] MODE_ASYNC8 = 2'h1;
	localparam logic [1:0] MODE_FIXED9 = 2'h2;
	localparam logic [1:0] MODE_VAR9   = 2'h3;

	localparam int SYNC_DIV_SLOW  = 12;
	localparam int SYNC_DIV_FAST  = 4;
	localparam int FIXED_DIV_SLOW = 64;
	localparam int FIXED_DIV_FAST = 32;
	localparam int OVERSAMPLE     = 16;
	localparam logic [3:0] SUB_LAST = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] SUB_HALF = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] BITS_8   = 4'h8;
	localparam logic [3:0] BITS_9   = 4'h9;
	localparam logic [15:0] BAUD_RESET = 16'h0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_DATA  = 4'h4,
		TX_STOP  = 4'h8
	} tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} rx_state_t;

endpackage

// ---- hw/serial_port_addr_match.sv ----
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module serial_port_addr_match
	import serial_port_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   txd,
	input  wire logic              rxd_in,
	output logic                   rxd_out,
	output logic                   rxd_oe_n,
	input  wire logic [7:0]        port1_rx_byte,
	input  wire logic              port1_rx_valid,
	output logic                   port1_addr_hit,
	output logic                   serial0_irq,
	output logic                   serial0_irq_high
);

	if (ADDR_W < 10) begin : g_bad_addr
		$error("ADDR_W must reach the register index bits");
	end

	// mask bits compare, zero mask bits ignore, all-zero mask accepts all
	function automatic logic addr_match(input logic [7:0] data, input logic [7:0] addr,
		input logic [7:0] mask);
		addr_match = ((data ^ addr) & mask) == 8'h00; // [RULE14] [RULE15] [RULE16]
	endfunction

	logic              aw_held;
	logic              w_held;
	logic [7:0]        widx;
	logic [31:0]       wdata;
	logic [3:0]        wstrb;
	logic              wr_fire;
	logic              ctrl_wr;
	logic              data_wr;
	logic              mode_hi;
	logic              mode_lo;
	logic              mp;
	logic              ren;
	logic              tb8;
	logic              rb8;
	logic              ti;
	logic              ri;
	logic              fe;
	logic              fe_sel;
	logic              double_rate;
	logic              gie;
	logic              es;
	logic              ps;
	logic [7:0]        saddr0;
	logic [7:0]        slave_address_port1;
	logic [7:0]        mask0;
	logic [7:0]        mask1;
	logic [15:0]       baud_div;
	logic [7:0]        rx_data;
	logic [1:0]        mode;
	logic [15:0]       tick_cnt;
	logic [15:0]       tick_period;
	logic              tick;
	logic [3:0]        sync_ph;
	logic [3:0]        sync_last;
	logic              sync_run;
	logic              sync_end;
	tx_state_t         tx_state;
	logic [8:0]        tx_shift;
	logic [3:0]        tx_sub;
	logic [3:0]        tx_bits;
	logic              tx_level;
	logic              tx_can;
	logic              ti_set;
	rx_state_t         rx_state;
	logic [8:0]        rx_shift;
	logic [3:0]        rx_sub;
	logic [3:0]        rx_bits;
	logic              rxd_s1;
	logic              rxd_s2;
	logic              rxd_prev;
	logic [3:0]        nbits;
	logic              rx0_done;
	logic              rxa_done;
	logic              rx_stop;
	logic [7:0]        rxa_byte;
	logic              rx_ninth;
	logic              rx_accept;
	logic              ri_set;
	logic              fe_set;
	logic [8:0]        rd_word;
	logic [8:0]        w_map;

	assign mode  = {mode_hi, mode_lo}; // [RULE1]
	assign nbits = (mode == MODE_ASYNC8) ? BITS_8 : BITS_9;

	// ---------------- bus slave ----------------
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign ctrl_wr = wr_fire && widx == IDX_CONTROL && wstrb[0];
	assign data_wr = wr_fire && widx == IDX_DATA && wstrb[0];

	// write answers reuse the read decode for the mapped flag
	always_comb begin
		w_map = read_map(widx);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			widx          <= 8'h00;
			wdata         <= 32'h0000_0000;
			wstrb         <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				widx    <= s_axi_awaddr[9:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata  <= s_axi_wdata;
				wstrb  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_map[8] ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// bit 8 flags a mapped index; same decode serves reads and write answers
	function automatic logic [8:0] read_map(input logic [7:0] idx);
		if (idx == IDX_CONTROL)
			read_map = {1'b1, fe_sel ? fe : mode_hi, mode_lo, mp, ren, tb8, rb8, ti, ri};
		else if (idx == IDX_DATA)
			read_map = {1'b1, rx_data}; // [RULE12]
		else if (idx == IDX_SADDR0)
			read_map = {1'b1, saddr0};
		else if (idx == IDX_SLAVE_ADDRESS_PORT1)
			read_map = {1'b1, slave_address_port1};
		else if (idx == IDX_MASK0)
			read_map = {1'b1, mask0};
		else if (idx == IDX_MASK1)
			read_map = {1'b1, mask1};
		else if (idx == IDX_POWER)
			read_map = {2'b11, fe_sel, 6'h00};
		else if (idx == IDX_IRQ_CTRL)
			read_map = {2'b11, 2'b00, es, 3'b000, ps};
		else if (idx == IDX_BAUD_LO)
			read_map = {1'b1, baud_div[7:0]};
		else if (idx == IDX_BAUD_HI)
			read_map = {1'b1, baud_div[15:8]};
		else
			read_map = 9'h000;
	endfunction

	always_comb begin
		rd_word = read_map(s_axi_araddr[9:2]);
		if (rd_word[8] && s_axi_araddr[9:2] == IDX_POWER)
			rd_word[BIT_DOUBLE] = double_rate;
		if (rd_word[8] && s_axi_araddr[9:2] == IDX_IRQ_CTRL)
			rd_word[BIT_GIE] = gie;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_word[7:0]};
				s_axi_rresp  <= rd_word[8] ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------- plain software registers ----------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			saddr0      <= 8'h00;
			slave_address_port1      <= 8'h00;
			mask0       <= 8'h00;
			mask1       <= 8'h00;
			fe_sel      <= 1'b0;
			double_rate <= 1'b0;
			gie         <= 1'b0;
			es          <= 1'b0;
			ps          <= 1'b0;
			baud_div    <= BAUD_RESET;
		end else if (wr_fire && wstrb[0]) begin
			if (widx == IDX_SADDR0)
				saddr0 <= wdata[7:0]; // [RULE13]
			else if (widx == IDX_SLAVE_ADDRESS_PORT1)
				slave_address_port1 <= wdata[7:0];
			else if (widx == IDX_MASK0)
				mask0 <= wdata[7:0];
			else if (widx == IDX_MASK1)
				mask1 <= wdata[7:0];
			else if (widx == IDX_POWER) begin
				fe_sel      <= wdata[BIT_FE_SEL];
				double_rate <= wdata[BIT_DOUBLE];
			end else if (widx == IDX_IRQ_CTRL) begin
				gie <= wdata[BIT_GIE];
				es  <= wdata[BIT_ES];
				ps  <= wdata[BIT_PS];
			end else if (widx == IDX_BAUD_LO)
				baud_div[7:0] <= wdata[7:0];
			else if (widx == IDX_BAUD_HI)
				baud_div[15:8] <= wdata[7:0];
		end
	end

	// ---------------- control register and flags ----------------
	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_hi <= 1'b0;
			mode_lo <= 1'b0;
			mp      <= 1'b0;
			ren     <= 1'b0;
			tb8     <= 1'b0;
			rb8     <= 1'b0;
			ti      <= 1'b0;
			ri      <= 1'b0;
			fe      <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				if (!fe_sel)
					mode_hi <= wdata[BIT_MODE_HI]; // [RULE2]
				mode_lo <= wdata[BIT_MODE_LO];
				mp      <= wdata[BIT_MP];
				ren     <= wdata[BIT_REN];
				tb8     <= wdata[BIT_TB8];
				rb8     <= wdata[BIT_RB8];
				ti      <= wdata[BIT_TI];
				ri      <= wdata[BIT_RI];
				if (fe_sel)
					fe <= wdata[BIT_MODE_HI]; // [RULE2]
			end
			if (ti_set)
				ti <= 1'b1; // [RULE10] [RULE22]
			if (fe_set)
				fe <= 1'b1; // [RULE3]
			if (ri_set) begin
				ri      <= 1'b1; // [RULE11]
				rx_data <= rx0_done ? {rxd_s2, rx_shift[8:2]} : rxa_byte;
			end
			if (rxa_done && rx_accept && !(mode == MODE_ASYNC8 && mp))
				rb8 <= rx_ninth; // [RULE9]
		end
	end

	// ---------------- rate generation ----------------
	// modes 2/3 and 1 oversample by sixteen; mode 2 ticks derive from the fixed divide
	assign tick_period = (mode == MODE_FIXED9) ?
		(double_rate ? 16'(FIXED_DIV_FAST / OVERSAMPLE - 1) :
			16'(FIXED_DIV_SLOW / OVERSAMPLE - 1)) : baud_div; // [RULE1]
	assign tick = tick_cnt == 16'h0000;

	always_ff @(posedge sys_clk) begin
		if (rst)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick ? tick_period : tick_cnt - 16'h0001;
	end

	assign sync_last = mp ? 4'(SYNC_DIV_FAST - 1) : 4'(SYNC_DIV_SLOW - 1); // [RULE6]
	assign sync_run  = mode == MODE_SYNC && (tx_state == TX_DATA || rx_state == RX_DATA);
	assign sync_end  = sync_run && sync_ph == sync_last;

	always_ff @(posedge sys_clk) begin
		if (rst || !sync_run)
			sync_ph <= 4'h0;
		else
			sync_ph <= sync_end ? 4'h0 : sync_ph + 4'h1;
	end

	// ---------------- transmitter ----------------
	// a data write while busy is dropped; software waits for the flag
	assign tx_can = tx_state == TX_IDLE && (mode != MODE_SYNC || rx_state == RX_IDLE);
	assign ti_set = tx_state == TX_DATA && (mode == MODE_SYNC ?
		(sync_end && tx_bits == BITS_8 - 4'h1) :
		(tick && tx_sub == SUB_LAST && tx_bits == nbits - 4'h1)); // [RULE10]

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_shift <= 9'h1FF;
			tx_sub   <= 4'h0;
			tx_bits  <= 4'h0;
		end else begin
			case (tx_state)
				TX_IDLE: begin
					if (data_wr && tx_can) begin // [RULE22]
						tx_shift <= {tb8, wdata[7:0]}; // [RULE8]
						tx_sub   <= 4'h0;
						tx_bits  <= 4'h0;
						tx_state <= (mode == MODE_SYNC) ? TX_DATA : TX_START;
					end
				end
				TX_START: begin
					if (tick) begin
						tx_sub <= tx_sub + 4'h1;
						if (tx_sub == SUB_LAST)
							tx_state <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (mode == MODE_SYNC ? sync_end : (tick && tx_sub == SUB_LAST)) begin
						tx_shift <= {1'b1, tx_shift[8:1]};
						tx_bits  <= tx_bits + 4'h1;
						if (ti_set)
							tx_state <= (mode == MODE_SYNC) ? TX_IDLE : TX_STOP;
					end
					if (tick && mode != MODE_SYNC)
						tx_sub <= tx_sub + 4'h1;
				end
				TX_STOP: begin
					if (tick) begin
						tx_sub <= tx_sub + 4'h1;
						if (tx_sub == SUB_LAST)
							tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	assign tx_level = (tx_state == TX_START) ? 1'b0 :
		(tx_state == TX_DATA) ? tx_shift[0] : 1'b1;

	// mode 0: data on the receive pin, shift clock on the transmit pin
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			txd      <= 1'b1;
			rxd_out  <= 1'b1;
			rxd_oe_n <= 1'b1;
		end else begin
			if (mode == MODE_SYNC)
				txd <= !sync_run || sync_ph > (sync_last >> 1); // [RULE21]
			else
				txd <= tx_level; // [RULE21]
			rxd_out  <= tx_shift[0];
			rxd_oe_n <= !(mode == MODE_SYNC && tx_state == TX_DATA);
		end
	end

	// ---------------- receiver ----------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rxd_s1   <= 1'b1;
			rxd_s2   <= 1'b1;
			rxd_prev <= 1'b1;
		end else begin
			rxd_s1   <= rxd_in;
			rxd_s2   <= rxd_s1;
			rxd_prev <= rxd_s2;
		end
	end

	assign rx0_done  = rx_state == RX_DATA && mode == MODE_SYNC && sync_end &&
		rx_bits == BITS_8 - 4'h1; // [RULE11]
	assign rxa_done  = rx_state == RX_STOP && tick && rx_sub == SUB_LAST;
	assign rx_stop   = rxd_s2;
	assign rxa_byte  = (mode == MODE_ASYNC8) ? rx_shift[8:1] : rx_shift[7:0];
	assign rx_ninth  = (mode == MODE_ASYNC8) ? rx_stop : rx_shift[8];
	assign rx_accept = !ri && ((mode == MODE_ASYNC8) ? (!mp || rx_stop) : // [RULE5]
		(!mp || (rx_ninth && addr_match(rxa_byte, saddr0, mask0)))); // [RULE4] [RULE14]
	assign ri_set    = rx0_done || (rxa_done && rx_accept); // [RULE11]
	assign fe_set    = rxa_done && !rx_stop; // [RULE3]

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_state <= RX_IDLE;
			rx_shift <= 9'h000;
			rx_sub   <= 4'h0;
			rx_bits  <= 4'h0;
		end else if (!ren) begin
			rx_state <= RX_IDLE; // [RULE7]
		end else begin
			case (rx_state)
				RX_IDLE: begin
					rx_sub  <= 4'h0;
					rx_bits <= 4'h0;
					if (mode == MODE_SYNC) begin
						if (!ri && tx_state == TX_IDLE && !data_wr)
							rx_state <= RX_DATA; // [RULE7]
					end else if (rxd_prev && !rxd_s2) begin
						rx_state <= RX_START; // [RULE7]
					end
				end
				RX_START: begin
					if (tick) begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == SUB_HALF) begin
							rx_sub   <= 4'h0;
							rx_state <= rxd_s2 ? RX_IDLE : RX_DATA;
						end
					end
				end
				RX_DATA: begin
					if (mode == MODE_SYNC ? sync_end : (tick && rx_sub == SUB_LAST)) begin
						rx_shift <= {rxd_s2, rx_shift[8:1]};
						rx_bits  <= rx_bits + 4'h1;
						if (mode == MODE_SYNC && rx_bits == BITS_8 - 4'h1)
							rx_state <= RX_IDLE;
						else if (mode != MODE_SYNC && rx_bits == nbits - 4'h1)
							rx_state <= RX_STOP;
					end
					if (tick && mode != MODE_SYNC)
						rx_sub <= rx_sub + 4'h1;
				end
				RX_STOP: begin
					if (tick) begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == SUB_LAST)
							rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// ---------------- second port match and interrupt ----------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port1_addr_hit   <= 1'b0;
			serial0_irq      <= 1'b0;
			serial0_irq_high <= 1'b0;
		end else begin
			port1_addr_hit   <= port1_rx_valid &&
				addr_match(port1_rx_byte, slave_address_port1, mask1); // [RULE17]
			serial0_irq      <= gie && es && (ti || ri); // [RULE18] [RULE19]
			serial0_irq_high <= gie && es && ps && (ti || ri); // [RULE20]
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence enter_stop_s;
		tx_state != TX_STOP ##1 tx_state == TX_STOP;
	endsequence

	sequence stop_sample_s;
		rx_state == RX_STOP && tick && rx_sub == SUB_LAST;
	endsequence

	tx_flag_stop_a: assert property (enter_stop_s |-> ti) // [RULE10]
		else $error("transmit flag not set at stop start");
	rx_ninth_gate_a: assert property (stop_sample_s and (mode[1] && mp && !rx_shift[8] &&
		!ctrl_wr) |=> ri == $past(ri)) // [RULE4]
		else $error("receive flag raised with ninth bit zero");
	rx_stop_gate_a: assert property (stop_sample_s and (mode == MODE_ASYNC8 && mp && !rxd_s2 &&
		!ctrl_wr) |=> ri == $past(ri)) // [RULE5]
		else $error("receive flag raised without valid stop");
	frame_err_a: assert property (stop_sample_s and !rxd_s2 |=> fe) // [RULE3]
		else $error("framing error not flagged");
	rx_disable_a: assert property (!ren |=> rx_state == RX_IDLE) // [RULE7]
		else $error("receiver active while disabled");
	irq_enable_a: assert property (serial0_irq |-> $past(es) && $past(ti || ri)) // [RULE18]
		else $error("interrupt without enable or flag");
	irq_global_a: assert property (!gie ##1 !gie |-> !serial0_irq) // [RULE19]
		else $error("interrupt passed global gate");
	irq_priority_a: assert property (serial0_irq_high |-> serial0_irq && $past(ps)) // [RULE20]
		else $error("high priority without priority bit");
	port1_match_a: assert property (port1_addr_hit |-> $past(port1_rx_valid) &&
		$past(((port1_rx_byte ^ slave_address_port1) & mask1) == 8'h00)) // [RULE17]
		else $error("second port hit on mismatched address");
	tx_start_a: assert property (tx_state == TX_IDLE && data_wr && tx_can &&
		mode != MODE_SYNC |=> tx_state == TX_START ##1 txd == 1'b0) // [RULE22]
		else $error("data write did not start frame");

endmodule

// ---- sim/serial_line_model.sv ----
`timescale 1ns/1ps
module serial_line_model (
	input  wire logic sys_clk,
	input  wire logic txd,
	output logic      line
);
	// fastest divisor setting: sixteen clocks to a bit
	localparam int BIT_CLKS = 16;

	initial line = 1'b1;

	// lsb first; the line idles high between frames
	task automatic send(input logic [7:0] d, input logic b9, input bit has9, input logic stp);
		logic [10:0] f;
		int          n;
		f = has9 ? {stp, b9, d, 1'b0} : {1'b0, stp, d, 1'b0};
		n = has9 ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			line <= f[i];
			repeat (BIT_CLKS) @(posedge sys_clk);
		end
		line <= 1'b1;
	endtask

	// samples mid-bit, counted from the start edge
	task automatic capture(input int n, input int bc, output logic [9:0] b);
		b = '0;
		wait (txd === 1'b0);
		repeat (bc / 2) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			repeat (bc) @(posedge sys_clk);
			b[i] = txd;
		end
	endtask
endmodule

// ---- sim/serial_port_addr_match_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module serial_port_addr_match_tb import serial_port_pkg::*;;
	logic        sys_clk, rst;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rsp;
	logic        txd, rxd_in, rxd_out, rxd_oe_n;
	logic [7:0]  p1_byte, rd;
	logic        p1_valid, p1_hit, irq, irq_hi;
	logic [9:0]  cap;
	logic [9:0]  irq_tab [4] = '{{8'h10, 2'b00}, {8'h90, 2'b10}, {8'h91, 2'b11}, {8'h81, 2'b00}};
	time         t0;
	int          n_mismatch, total_checks;

	serial_port_addr_match #(.ADDR_W(12)) u_serial_port_addr_match (
		.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.txd(txd), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
		.port1_rx_byte(p1_byte), .port1_rx_valid(p1_valid), .port1_addr_hit(p1_hit),
		.serial0_irq(irq), .serial0_irq_high(irq_hi)
	);

	serial_line_model u_serial_line_model (.sys_clk(sys_clk), .txd(txd), .line(rxd_in));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge sys_clk);
		awaddr  <= ad(i);
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd8(input logic [7:0] i);
		@(posedge sys_clk);
		araddr  <= ad(i);
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata[7:0];
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic expect_reg(input string n, input logic [7:0] i, input logic [7:0] m,
		input logic [7:0] e);
		rd8(i);
		`CHK(n, e, rd & m)
	endtask

	// control is rewritten first so every frame starts with the receive flag clear
	task automatic rx_case(input string n, input logic [7:0] ctl, input logic [7:0] d,
		input logic b9, input bit has9, input logic stp, input logic [7:0] m, input logic [7:0] e);
		wr(IDX_CONTROL, ctl);
		u_serial_line_model.send(d, b9, has9, stp);
		repeat (20) @(posedge sys_clk);
		expect_reg(n, IDX_CONTROL, m, e);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		end_of_test();
	end

	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, p1_valid} = '0;
		{awaddr, araddr, wdata, p1_byte} = '0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		expect_reg("control_rst", IDX_CONTROL, 8'hFF, 8'h00);
		wr(IDX_SADDR0, 8'h50);
		expect_reg("saddr0", IDX_SADDR0, 8'hFF, 8'h50);
		rd8(8'h00);
		`CHK("unmapped", RESP_SLVERR, rsp)
		$display("test registers done");

		// mode 1 must not send the ninth bit even with it set; mode 2 runs 32 clocks a bit
		for (int m = 0; m < 3; m++) begin
			wr(IDX_POWER, (m == 2) ? 8'h80 : 8'h00);
			wr(IDX_CONTROL, (m == 2) ? 8'h88 : (m ? 8'hC8 : 8'h48));
			fork
				u_serial_line_model.capture(m ? 10 : 9, (m == 2) ? 32 : 16, cap);
				wr(IDX_DATA, 8'h96);
			join
			`CHK("tx_frame", {(m ? 2'b11 : 2'b01), 8'h96}, cap)
			expect_reg("tx_done", IDX_CONTROL, 8'h02, 8'h02);
		end
		foreach (irq_tab[k]) begin
			wr(IDX_IRQ_CTRL, irq_tab[k][9:2]);
			repeat (2) @(posedge sys_clk);
			`CHK("irq", irq_tab[k][1:0], {irq, irq_hi})
		end
		$display("test transmit done");

		repeat (20) @(posedge sys_clk);
		for (int f = 0; f < 2; f++) begin
			wr(IDX_CONTROL, f ? 8'h20 : 8'h00);
			fork
				wr(IDX_DATA, 8'h5A);
				begin
					@(negedge txd);
					t0 = $time;
					#1;
					`CHK("oe_n", 1'b0, rxd_oe_n)
					`CHK("sync_bit0", 1'b0, rxd_out)
					@(negedge txd);
					`CHK("shift_clk", (f ? 4 : 12), int'(($time - t0) / 10))
					#1;
					`CHK("sync_bit1", 1'b1, rxd_out)
				end
			join
			repeat (120) @(posedge sys_clk);
			expect_reg("sync_done", IDX_CONTROL, 8'h02, 8'h02);
		end
		// mode 0 receive shifts in the idle-high pin at once
		wr(IDX_CONTROL, 8'h10);
		repeat (120) @(posedge sys_clk);
		expect_reg("sync_rx", IDX_CONTROL, 8'h01, 8'h01);
		expect_reg("sync_rx_data", IDX_DATA, 8'hFF, 8'hFF);
		$display("test sync done");

		rx_case("m1_rx", 8'h50, 8'h3C, 1'b0, 0, 1'b1, 8'hFF, 8'h55);
		expect_reg("rx_data", IDX_DATA, 8'hFF, 8'h3C);
		rx_case("ren_off", 8'h40, 8'hAA, 1'b0, 0, 1'b1, 8'h01, 8'h00);
		rx_case("mp_stop", 8'h70, 8'h11, 1'b0, 0, 1'b0, 8'h01, 8'h00);
		wr(IDX_POWER, 8'h40);
		rx_case("fe_set", 8'h70, 8'h11, 1'b0, 0, 1'b0, 8'h81, 8'h80);
		wr(IDX_CONTROL, 8'h70);
		expect_reg("fe_clear", IDX_CONTROL, 8'h80, 8'h00);
		wr(IDX_POWER, 8'h00);
		rx_case("m3_rb8", 8'hD0, 8'h00, 1'b1, 1, 1'b1, 8'h05, 8'h05);
		wr(IDX_MASK0, 8'hF0);
		rx_case("addr_hit", 8'hF0, 8'h5A, 1'b1, 1, 1'b1, 8'h01, 8'h01);
		rx_case("addr_miss", 8'hF0, 8'h6A, 1'b1, 1, 1'b1, 8'h01, 8'h00);
		rx_case("ninth_zero", 8'hF0, 8'h5A, 1'b0, 1, 1'b1, 8'h01, 8'h00);
		wr(IDX_MASK0, 8'h00);
		rx_case("mask_zero", 8'hF0, 8'hC3, 1'b1, 1, 1'b1, 8'h01, 8'h01);
		$display("test receive done");

		wr(IDX_SLAVE_ADDRESS_PORT1, 8'h33);
		wr(IDX_MASK1, 8'h0F);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			p1_byte  <= k ? 8'hA4 : 8'hA3;
			p1_valid <= 1'b1;
			@(posedge sys_clk);
			p1_valid <= 1'b0;
			#1;
			`CHK("port1_hit", (k == 0), p1_hit)
		end
		$display("test port1 done");
		end_of_test();
	end
endmodule
